/* core/scrc_pkg.sv */
// constants, field positions and types of the reset and clock controller
package scrc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [31:0] OFS_RESET_GATE = 32'h40000018;
    localparam logic [31:0] OFS_CAUSE = 32'h4000001c;
    localparam logic [31:0] OFS_RMASK_A = 32'h40000020;
    localparam logic [31:0] OFS_RMASK_B = 32'h40000024;
    localparam logic [31:0] OFS_FEN_A = 32'h40000028;
    localparam logic [31:0] OFS_FEN_B = 32'h4000002c;
    localparam logic [31:0] OFS_CGATE_A = 32'h40000030;
    localparam logic [31:0] OFS_CGATE_B = 32'h40000034;
    localparam logic [31:0] OFS_OSC = 32'h40000040;
    localparam logic [31:0] OFS_CLKSEL = 32'h40000044;
    localparam logic [31:0] OFS_MON = 32'h40000048;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_RESET_GATE = 8'h49;
    localparam logic [7:0] RST_CAUSE = 8'h80;
    localparam logic [31:0] RST_RMASK_A = 32'h03ff1f1f;
    localparam logic [31:0] RST_RMASK_B = 32'h00f30f33;
    localparam logic [31:0] RST_FEN_A = 32'h0000000f;
    localparam logic [31:0] RST_FEN_B = 32'h00000101;
    localparam logic [31:0] RST_CGATE_A = 32'h0000000f;
    localparam logic [31:0] RST_CGATE_B = 32'h00000101;
    localparam logic [7:0] RST_OSC = 8'h20;
    localparam logic [7:0] RST_CLKSEL = 8'h00;
    localparam logic [15:0] RST_MON = 16'h0090;

    ////////////////////////////////////////////////////////////////////////
    // implemented and writable bits
    localparam logic [7:0] GATE_BITS = 8'h7f;
    localparam logic [31:0] BANK_A_BITS = 32'h030f0f1f;
    localparam logic [31:0] BANK_B_BITS = 32'h00f30f33;
    localparam logic [31:0] FEN_A_BITS = 32'h030f0f10;
    localparam logic [31:0] FEN_A_FIXED = 32'h0000000f;
    localparam logic [7:0] OSC_BITS = 8'h3f;
    localparam logic [7:0] CLKSEL_BITS = 8'h07;
    localparam logic [15:0] MON_RW_BITS = 16'h80cc;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CAUSE_POWER_ON = 7;
    localparam int CAUSE_MAIN_FAIL = 2;
    localparam int CAUSE_XTAL_FAIL = 1;
    localparam int OSC_RING_LSB = 4;
    localparam int OSC_INT_LSB = 2;
    localparam int OSC_XTAL_LSB = 0;
    localparam int PLL_IN_BIT = 2;
    localparam int MSEL_LSB = 0;
    localparam int MON_REC_OFF = 15;
    localparam int MON_M_WATCH = 7;
    localparam int MON_M_IRQ = 6;
    localparam int MON_M_PEND = 5;
    localparam int MON_M_PRES = 4;
    localparam int MON_X_WATCH = 3;
    localparam int MON_X_IRQ = 2;
    localparam int MON_X_PEND = 1;
    localparam int MON_X_RUN = 0;

    ////////////////////////////////////////////////////////////////////////
    // codes, timing and types
    localparam logic [1:0] MSEL_BYPASS = 2'b10;
    localparam logic [1:0] MSEL_PLL = 2'b11;
    localparam logic [2:0] SRC_RING = 3'b001;
    localparam logic [2:0] SRC_BYPASS = 3'b010;
    localparam logic [2:0] SRC_PLL = 3'b100;
    localparam logic [2:0] SRC_NONE = 3'b000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SWITCH_GAP_NS = 20;
    localparam int SWITCH_GAP_CYC =
        (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] SWITCH_GAP_LAST = 2'(SWITCH_GAP_CYC - 1);
    localparam logic [2:0] LOSS_REF_LAST = 3'h3;

    typedef enum logic [0:0]
    {
        SW_RUN = 1'b0,
        SW_GAP = 1'b1
    } scrc_switch_state_t;

endpackage

/* core/scrc_top.sv */
// reset cause, peripheral reset and clock gating, oscillator and clock
// selection, clock monitor with fallback to the ring oscillator
//
// How it works
// R01 - eight reset cause flags, power-on at top
// R02 - writing one clears a cause flag
// R03 - reset mask bit lets event reset through
// R04 - bank a mask: timers, ports, dma, system
// R05 - bank b mask: analog, pwm, uart, i2c, spi
// R06 - function enable zero holds peripheral in reset
// R07 - bank a enables share mask positions
// R08 - clock gate bit zero stops peripheral clock
// R09 - three oscillator fields: off, on, halved
// R10 - pll input: internal zero, crystal one
// R11 - main select: ring, bypass, pll output
// R12 - software keeps both oscillators up first
// R13 - monitor counts ring oscillator reference edges
// R14 - main clock watch, irq enable, pending
// R15 - crystal watch, irq enable, pending
// R16 - pending reads one, write one clears
// R17 - main failure forces ring unless recovery off
// R18 - live main present and crystal running
// R19 - disabled reset sources never reach generator
// R20 - monitored failure reset sets its cause
// R21 - clock source switches break before make
module scrc_top
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    input wire logic pinResetIn,
    input wire logic cpuResetReq,
    input wire logic softwareResetReq,
    input wire logic watchdogResetReq,
    input wire logic brownoutIn,
    input wire logic ringOscIn,
    input wire logic mainClockIn,
    input wire logic crystalIn,
    output logic eventReset,
    output logic [31:0] periphResetA,
    output logic [31:0] periphResetB,
    output logic [31:0] periphClockGateA,
    output logic [31:0] periphClockGateB,
    output logic [1:0] ringOscCtrl,
    output logic [1:0] internalOscCtrl,
    output logic [1:0] crystalOscCtrl,
    output logic pllInputSelect,
    output logic [2:0] mainClockSource,
    output logic mainClockFailIrq,
    output logic crystalFailIrq
);
    import scrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers: bit order ring, main, crystal, then the
    // five reset requests; stage one feeds stage two only
    logic [7:0] asyncIn;
    logic [7:0] syncA_reg;
    logic [7:0] syncB_reg;
    logic [7:0] syncLast_reg;
    logic [7:0] syncRise;

    assign asyncIn = {brownoutIn, watchdogResetReq, softwareResetReq,
                      cpuResetReq, pinResetIn, crystalIn, mainClockIn,
                      ringOscIn};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_sync
            always_ff @(posedge clk_sys)
            begin
                if (!reset_n)
                begin
                    syncA_reg[gi] <= 1'b0;
                    syncB_reg[gi] <= 1'b0;
                    syncLast_reg[gi] <= 1'b0;
                end
                else if (clkEn)
                begin
                    syncA_reg[gi] <= asyncIn[gi];
                    syncB_reg[gi] <= syncA_reg[gi];
                    syncLast_reg[gi] <= syncB_reg[gi];
                end
            end
            assign syncRise[gi] = syncB_reg[gi] & ~syncLast_reg[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] resetGate_reg;
    logic [7:0] cause_reg;
    logic [7:0] cause_next;
    logic [31:0] rmaskA_reg;
    logic [31:0] rmaskB_reg;
    logic [31:0] fenA_reg;
    logic [31:0] fenB_reg;
    logic [31:0] cgateA_reg;
    logic [31:0] cgateB_reg;
    logic [7:0] osc_reg;
    logic [7:0] clkSel_reg;
    logic [15:0] monCtrl_reg;
    logic mainPend_reg;
    logic mainPend_next;
    logic xtalPend_reg;
    logic xtalPend_next;

    // address decode
    logic hitGate;
    logic hitCause;
    logic hitRmaskA;
    logic hitRmaskB;
    logic hitFenA;
    logic hitFenB;
    logic hitCgateA;
    logic hitCgateB;
    logic hitOsc;
    logic hitClkSel;
    logic hitMon;
    assign hitGate = regAddr == OFS_RESET_GATE;
    assign hitCause = regAddr == OFS_CAUSE;
    assign hitRmaskA = regAddr == OFS_RMASK_A;
    assign hitRmaskB = regAddr == OFS_RMASK_B;
    assign hitFenA = regAddr == OFS_FEN_A;
    assign hitFenB = regAddr == OFS_FEN_B;
    assign hitCgateA = regAddr == OFS_CGATE_A;
    assign hitCgateB = regAddr == OFS_CGATE_B;
    assign hitOsc = regAddr == OFS_OSC;
    assign hitClkSel = regAddr == OFS_CLKSEL;
    assign hitMon = regAddr == OFS_MON;

    ////////////////////////////////////////////////////////////////////////
    // clock monitor: channel 0 main clock, channel 1 crystal; a channel
    // is lost after LOSS_REF_LAST+1 ring edges with no edge of its own
    logic [1:0] chanRise;
    logic [1:0] chanWatch;
    logic [1:0] chanPresent_reg;
    logic [1:0] chanLoss;
    logic [2:0] refCount_reg [2];
    logic ringRise;

    assign ringRise = syncRise[0]; // [R13]
    assign chanRise = syncRise[2:1];
    assign chanWatch = {monCtrl_reg[MON_X_WATCH], monCtrl_reg[MON_M_WATCH]};

    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_mon
            logic atLimit;
            assign atLimit = refCount_reg[gi] == LOSS_REF_LAST;
            // loss is reported once, on the present-to-absent step
            assign chanLoss[gi] = ringRise & ~chanRise[gi] & atLimit
                                  & chanPresent_reg[gi] & chanWatch[gi];
            always_ff @(posedge clk_sys)
            begin
                if (!reset_n)
                begin
                    refCount_reg[gi] <= 3'h0;
                    chanPresent_reg[gi] <= 1'b1;
                end
                else if (clkEn)
                begin
                    if (chanRise[gi])
                    begin
                        refCount_reg[gi] <= 3'h0;
                        chanPresent_reg[gi] <= 1'b1; // [R18]
                    end
                    else if (ringRise)
                    begin
                        if (atLimit)
                            chanPresent_reg[gi] <= 1'b0; // [R18]
                        else
                            refCount_reg[gi] <= refCount_reg[gi] + 3'h1;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // reset events: only enabled sources go on, monitored losses take
    // the two clock-fail slots
    logic [7:0] rawEvent;
    logic [7:0] gatedEvent;
    logic anyEvent;
    assign rawEvent = {1'b0, syncRise[3], syncRise[4], syncRise[5],
                       syncRise[6], chanLoss[0], chanLoss[1], syncRise[7]};
    assign gatedEvent = rawEvent & resetGate_reg & GATE_BITS; // [R19] [R20]
    assign anyEvent = |gatedEvent;

    // set wins over a clear in the same cycle
    logic [7:0] causeClr;
    assign causeClr = (regWrite & hitCause) ? regWrData[7:0] : 8'h00;
    assign cause_next = (cause_reg & ~causeClr) | gatedEvent; // [R01] [R02]

    logic mainPendClr;
    logic xtalPendClr;
    assign mainPendClr = regWrite & hitMon & regWrData[MON_M_PEND];
    assign xtalPendClr = regWrite & hitMon & regWrData[MON_X_PEND];
    assign mainPend_next = (mainPend_reg & ~mainPendClr) | chanLoss[0];
    assign xtalPend_next = (xtalPend_reg & ~xtalPendClr) | chanLoss[1];

    ////////////////////////////////////////////////////////////////////////
    // peripheral reset and clock gate outputs
    logic [31:0] fenAEff;
    logic [31:0] resetA_next;
    logic [31:0] resetB_next;
    assign fenAEff = (fenA_reg & FEN_A_BITS) | FEN_A_FIXED; // [R07]
    assign resetA_next = ((~fenAEff) // [R06]
        | (rmaskA_reg & {32{anyEvent}})) & BANK_A_BITS; // [R03] [R04]
    assign resetB_next = ((~fenB_reg) // [R06]
        | (rmaskB_reg & {32{anyEvent}})) & BANK_B_BITS; // [R03] [R05]

    ////////////////////////////////////////////////////////////////////////
    // main clock source: fallback overrides software's choice
    logic recoverNow;
    logic [1:0] mselCode;
    logic [2:0] targetSrc;
    assign recoverNow = ~monCtrl_reg[MON_REC_OFF] & mainPend_reg; // [R17]
    assign mselCode = clkSel_reg[MSEL_LSB +: 2];
    assign targetSrc = recoverNow ? SRC_RING
        : (mselCode == MSEL_PLL) ? SRC_PLL // [R11]
        : (mselCode == MSEL_BYPASS) ? SRC_BYPASS
        : SRC_RING;

    // break before make: all sources off for the gap, then the new one;
    // costs a few cycles of no clock but never a runt pulse
    scrc_switch_state_t swState_reg;
    scrc_switch_state_t swState_next;
    logic [1:0] gapCount_reg;
    logic [1:0] gapCount_next;
    logic [2:0] source_next;
    always_comb
    begin
        swState_next = swState_reg;
        gapCount_next = gapCount_reg;
        source_next = mainClockSource;
        unique case (swState_reg)
            SW_RUN:
            begin
                if (targetSrc != mainClockSource)
                begin
                    source_next = SRC_NONE; // [R21]
                    gapCount_next = 2'h0;
                    swState_next = SW_GAP;
                end
            end
            SW_GAP:
            begin
                if (gapCount_reg == SWITCH_GAP_LAST)
                begin
                    source_next = targetSrc; // [R21]
                    swState_next = SW_RUN;
                end
                else
                    gapCount_next = gapCount_reg + 2'h1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read zero
    logic [15:0] monRead;
    logic [31:0] rdMux;
    assign monRead = (monCtrl_reg & MON_RW_BITS)
        | ({15'h0, mainPend_reg} << MON_M_PEND) // [R16]
        | ({15'h0, xtalPend_reg} << MON_X_PEND)
        | ({15'h0, chanPresent_reg[0]} << MON_M_PRES) // [R18]
        | ({15'h0, chanPresent_reg[1]} << MON_X_RUN);
    assign rdMux = hitGate ? {24'h0, resetGate_reg & GATE_BITS}
        : hitCause ? {24'h0, cause_reg}
        : hitRmaskA ? rmaskA_reg & BANK_A_BITS
        : hitRmaskB ? rmaskB_reg & BANK_B_BITS
        : hitFenA ? fenAEff
        : hitFenB ? fenB_reg & BANK_B_BITS
        : hitCgateA ? (cgateA_reg & FEN_A_BITS) | FEN_A_FIXED
        : hitCgateB ? cgateB_reg & BANK_B_BITS
        : hitOsc ? {24'h0, osc_reg & OSC_BITS}
        : hitClkSel ? {24'h0, clkSel_reg & CLKSEL_BITS}
        : hitMon ? {16'h0, monRead}
        : 32'h0;

    ////////////////////////////////////////////////////////////////////////
    // software registers; masks write reserved bits as zero
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            resetGate_reg <= RST_RESET_GATE;
            rmaskA_reg <= RST_RMASK_A;
            rmaskB_reg <= RST_RMASK_B;
            fenA_reg <= RST_FEN_A;
            fenB_reg <= RST_FEN_B;
            cgateA_reg <= RST_CGATE_A;
            cgateB_reg <= RST_CGATE_B;
            osc_reg <= RST_OSC;
            clkSel_reg <= RST_CLKSEL;
            monCtrl_reg <= RST_MON;
        end
        else if (clkEn && regWrite)
        begin
            if (hitGate)
                resetGate_reg <= regWrData[7:0] & GATE_BITS; // [R19]
            if (hitRmaskA)
                rmaskA_reg <= regWrData & BANK_A_BITS; // [R04]
            if (hitRmaskB)
                rmaskB_reg <= regWrData & BANK_B_BITS; // [R05]
            if (hitFenA)
                fenA_reg <= regWrData & FEN_A_BITS; // [R07]
            if (hitFenB)
                fenB_reg <= regWrData & BANK_B_BITS;
            if (hitCgateA)
                cgateA_reg <= regWrData & FEN_A_BITS;
            if (hitCgateB)
                cgateB_reg <= regWrData & BANK_B_BITS;
            if (hitOsc)
                osc_reg <= regWrData[7:0] & OSC_BITS; // [R09]
            if (hitClkSel)
                clkSel_reg <= regWrData[7:0] & CLKSEL_BITS; // [R10]
            if (hitMon)
                monCtrl_reg <= regWrData[15:0] & MON_RW_BITS; // [R14] [R15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags, switch state and outputs
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            cause_reg <= RST_CAUSE; // [R01]
            mainPend_reg <= 1'b0;
            xtalPend_reg <= 1'b0;
            swState_reg <= SW_RUN;
            gapCount_reg <= 2'h0;
            mainClockSource <= SRC_RING;
            regRdData <= 32'h0;
            eventReset <= 1'b0;
            periphResetA <= 32'h0;
            periphResetB <= 32'h0;
            periphClockGateA <= 32'h0;
            periphClockGateB <= 32'h0;
            ringOscCtrl <= RST_OSC[OSC_RING_LSB +: 2];
            internalOscCtrl <= RST_OSC[OSC_INT_LSB +: 2];
            crystalOscCtrl <= RST_OSC[OSC_XTAL_LSB +: 2];
            pllInputSelect <= 1'b0;
            mainClockFailIrq <= 1'b0;
            crystalFailIrq <= 1'b0;
        end
        else if (clkEn)
        begin
            cause_reg <= cause_next; // [R02] [R20]
            mainPend_reg <= mainPend_next; // [R14] [R16]
            xtalPend_reg <= xtalPend_next; // [R15] [R16]
            swState_reg <= swState_next;
            gapCount_reg <= gapCount_next;
            mainClockSource <= source_next;
            regRdData <= regRead ? rdMux : 32'h0;
            eventReset <= anyEvent; // [R19]
            periphResetA <= resetA_next;
            periphResetB <= resetB_next;
            periphClockGateA <= (cgateA_reg & FEN_A_BITS) | FEN_A_FIXED; // [R08]
            periphClockGateB <= cgateB_reg & BANK_B_BITS; // [R08]
            ringOscCtrl <= osc_reg[OSC_RING_LSB +: 2]; // [R09]
            internalOscCtrl <= osc_reg[OSC_INT_LSB +: 2];
            crystalOscCtrl <= osc_reg[OSC_XTAL_LSB +: 2];
            pllInputSelect <= clkSel_reg[PLL_IN_BIT]; // [R10]
            mainClockFailIrq <= mainPend_reg & monCtrl_reg[MON_M_IRQ]; // [R14]
            crystalFailIrq <= xtalPend_reg & monCtrl_reg[MON_X_IRQ]; // [R15]
        end
    end

endmodule // scrc_top

/* tb/scrc_top_properties.sv */
// port-level checks of the reset and clock controller
module scrc_properties
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic eventReset,
    input wire logic [31:0] periphResetA,
    input wire logic [31:0] periphClockGateA,
    input wire logic [1:0] ringOscCtrl,
    input wire logic [1:0] internalOscCtrl,
    input wire logic [1:0] crystalOscCtrl,
    input wire logic pllInputSelect,
    input wire logic [2:0] mainClockSource,
    input wire logic mainClockFailIrq
);
    import scrc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n || !clkEn);

    // write decodes
    wire logic wrOsc = regWrite && regAddr == OFS_OSC;
    wire logic wrSel = regWrite && regAddr == OFS_CLKSEL;
    wire logic wrGate = regWrite && regAddr == OFS_CGATE_A;
    wire logic wrFen = regWrite && regAddr == OFS_FEN_A;
    wire logic wrMon = regWrite && regAddr == OFS_MON;
    wire logic selData = regWrData[PLL_IN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // a lone write, then a quiet cycle
    sequence lone_s(w);
        w ##1 !w;
    endsequence

    // two idle cycles, then a live source
    sequence gap_s;
        (mainClockSource == SRC_NONE) [*2] ##1 mainClockSource != SRC_NONE;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    osc_fields_a:
    assert property (lone_s(wrOsc) |=> {ringOscCtrl, internalOscCtrl,
        crystalOscCtrl} == 6'($past(regWrData, 2)))
        else $error("osc fields wrong");

    pll_input_a:
    assert property (lone_s(wrSel) |=> pllInputSelect == $past(selData, 2))
        else $error("pll select wrong");

    clock_gate_a:
    assert property (lone_s(wrGate) |=> periphClockGateA ==
        ($past(regWrData, 2) & FEN_A_BITS | FEN_A_FIXED))
        else $error("gates wrong");

    func_reset_a:
    assert property (lone_s(wrFen) ##1 !eventReset |-> periphResetA ==
        (~($past(regWrData, 2) | FEN_A_FIXED) & BANK_A_BITS))
        else $error("resets wrong");

    irq_off_a:
    assert property (wrMon && !regWrData[MON_M_IRQ] ##1 !wrMon
        |=> !mainClockFailIrq)
        else $error("irq despite enable off");

    source_onehot_a:
    assert property ($onehot0(mainClockSource))
        else $error("source not one-hot");

    break_make_a:
    assert property (mainClockSource != $past(mainClockSource) &&
        $past(mainClockSource) != SRC_NONE |-> mainClockSource == SRC_NONE)
        else $error("switch without gap");

    gap_len_a:
    assert property (mainClockSource == SRC_NONE &&
        $past(mainClockSource) != SRC_NONE |-> gap_s)
        else $error("gap not two cycles");
endmodule // scrc_properties

// checks on every controller instance
bind scrc_top scrc_properties i_props (.*);

/* tb/test_system_reset_clock_control.sv */
// self-checking bench of the reset and clock controller
`define CHK(what, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
        end \
    end

module test_system_reset_clock_control;
    timeunit 1ns;
    timeprecision 1ps;
    import scrc_pkg::*;

    localparam logic [31:0] ADR [13] = '{OFS_RESET_GATE, OFS_CAUSE,
        OFS_RMASK_A, OFS_RMASK_B, OFS_FEN_A, OFS_FEN_B, OFS_CGATE_A,
        OFS_CGATE_B, OFS_OSC, OFS_CLKSEL, OFS_MON, 32'h4000004c, 32'h40000050};
    localparam logic [31:0] RST [13] = '{32'h49, 32'h80, 32'h030f0f1f,
        32'h00f30f33, 32'hf, 32'h101, 32'hf, 32'h101, 32'h20, 32'h0,
        32'h91, 32'h0, 32'h0};
    localparam logic [1:0] SEQ [4] = '{2'b10, 2'b11, 2'b00, 2'b01};
    localparam logic [2:0] SRCX [4] = '{SRC_BYPASS, SRC_PLL, SRC_RING, SRC_RING};

    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] regAddr = 32'h0;
    logic [31:0] regWrData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [1:0] req = 2'h0;
    logic [2:0] cnt = 3'h0;
    logic ringOscIn = 1'b0;
    logic mainClockIn = 1'b0;
    logic crystalIn = 1'b0;
    logic ringRun = 1'b0;
    logic mainRun = 1'b1;
    logic xtalRun = 1'b1;
    logic seen;
    logic [31:0] pa, pb, regRdData, periphResetA, periphResetB;
    logic [31:0] periphClockGateA, periphClockGateB;
    logic [1:0] ringOscCtrl, internalOscCtrl, crystalOscCtrl;
    logic [2:0] mainClockSource;
    logic eventReset, pllInputSelect, mainClockFailIrq, crystalFailIrq;
    int num_errors = 0;
    int comparisons = 0;

    always #5 clk_sys = ~clk_sys;

    // slow clocks; stopping one models a loss
    always @(posedge clk_sys)
    begin
        cnt <= cnt + 3'h1;
        ringOscIn <= ringRun & cnt[2];
        mainClockIn <= mainRun & cnt[1];
        crystalIn <= xtalRun & cnt[1];
    end

    scrc_top i_dut
    (
        .clk_sys, .reset_n, .clkEn(1'b1), .regAddr, .regWrData, .regWrite,
        .regRead, .regRdData, .pinResetIn(req[0]), .cpuResetReq(1'b0),
        .softwareResetReq(req[1]), .watchdogResetReq(1'b0),
        .brownoutIn(1'b0), .ringOscIn, .mainClockIn, .crystalIn,
        .eventReset, .periphResetA, .periphResetB, .periphClockGateA,
        .periphClockGateB, .ringOscCtrl, .internalOscCtrl, .crystalOscCtrl,
        .pllInputSelect, .mainClockSource, .mainClockFailIrq, .crystalFailIrq
    );

    ////////////////////////////////////////////////////////////////////////
    // one-cycle strobes; read data next cycle
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        `CHK($sformatf("read %h", a), e, regRdData)
    endtask

    // let registered outputs land
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    // pulse a request, catch the reset
    task automatic evt(input int i);
        seen = 1'b0;
        @(posedge clk_sys);
        req[i] <= 1'b1;
        repeat (8)
        begin
            @(posedge clk_sys);
            #1;
            if (eventReset === 1'b1)
            begin
                seen = 1'b1;
                pa = periphResetA;
                pb = periphResetB;
            end
        end
        @(posedge clk_sys);
        req[i] <= 1'b0;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // ring still first: monitor quiet
    initial
    begin
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        settle();
        `CHK("reset a", 32'h030f0f10, periphResetA)
        `CHK("reset b", 32'h00f30e32, periphResetB)
        for (int k = 0; k < 13; k++)
            rd(ADR[k], RST[k]);
        wr(OFS_CAUSE, 32'h7f);
        rd(OFS_CAUSE, 32'h80);
        wr(OFS_CAUSE, 32'h80);
        rd(OFS_CAUSE, 32'h0);
        // masks pick what an event reaches
        wr(OFS_FEN_A, 32'hffffffff);
        rd(OFS_FEN_A, 32'h030f0f1f);
        wr(OFS_FEN_B, 32'hffffffff);
        wr(OFS_RMASK_A, 32'h01000101);
        wr(OFS_RMASK_B, 32'h00100002);
        evt(0);
        `CHK("pin event", 1'b1, seen)
        `CHK("pulse a", 32'h01000101, pa)
        `CHK("pulse b", 32'h00100002, pb)
        `CHK("quiet a", 32'h0, periphResetA)
        rd(OFS_CAUSE, 32'h40);
        wr(OFS_CAUSE, 32'h40);
        wr(OFS_RESET_GATE, 32'h0);
        evt(1);
        `CHK("gated event", 1'b0, seen)
        rd(OFS_CAUSE, 32'h0);
        wr(OFS_RESET_GATE, 32'h10);
        evt(1);
        rd(OFS_CAUSE, 32'h10);
        wr(OFS_FEN_A, 32'h030f0f0f);
        settle();
        `CHK("dma held", 32'h10, periphResetA)
        wr(OFS_CGATE_A, 32'hffffffff);
        wr(OFS_CGATE_B, 32'h0);
        settle();
        `CHK("gate a", 32'h030f0f1f, periphClockGateA)
        `CHK("gate b", 32'h0, periphClockGateB)
        // every oscillator code
        for (int k = 0; k < 4; k++)
        begin
            wr(OFS_OSC, 32'(k * 21));
            settle();
            `CHK("ring", 2'(k), ringOscCtrl)
            `CHK("internal", 2'(k), internalOscCtrl)
            `CHK("crystal", 2'(k), crystalOscCtrl)
        end
        // every main select code
        for (int k = 0; k < 4; k++)
        begin
            wr(OFS_CLKSEL, {29'h0, 1'b1, SEQ[k]});
            repeat (6) @(posedge clk_sys);
            #1;
            `CHK("pll input", 1'b1, pllInputSelect)
            `CHK("source", SRCX[k], mainClockSource)
        end
        // dead main clock falls back to ring
        wr(OFS_CLKSEL, 32'h3);
        wr(OFS_CAUSE, 32'hff);
        wr(OFS_RESET_GATE, 32'h04);
        wr(OFS_MON, 32'h00cc);
        ringRun <= 1'b1;
        repeat (40) @(posedge clk_sys);
        #1;
        `CHK("pll input", 1'b0, pllInputSelect)
        rd(OFS_MON, 32'h00dd);
        mainRun <= 1'b0;
        repeat (80) @(posedge clk_sys);
        #1;
        `CHK("main irq", 1'b1, mainClockFailIrq)
        `CHK("fallback", SRC_RING, mainClockSource)
        rd(OFS_MON, 32'h00ed);
        rd(OFS_CAUSE, 32'h04);
        mainRun <= 1'b1;
        repeat (20) @(posedge clk_sys);
        wr(OFS_MON, 32'h00ec);
        repeat (6) @(posedge clk_sys);
        #1;
        `CHK("main irq", 1'b0, mainClockFailIrq)
        `CHK("source", SRC_PLL, mainClockSource)
        rd(OFS_MON, 32'h00dd);
        // recovery off: pll stays
        wr(OFS_RESET_GATE, 32'h0);
        wr(OFS_MON, 32'h80cc);
        mainRun <= 1'b0;
        xtalRun <= 1'b0;
        repeat (80) @(posedge clk_sys);
        #1;
        `CHK("source", SRC_PLL, mainClockSource)
        `CHK("crystal irq", 1'b1, crystalFailIrq)
        rd(OFS_MON, 32'h80ee);
        rd(OFS_CAUSE, 32'h04);
        wr(OFS_MON, 32'h8088);
        settle();
        `CHK("main irq", 1'b0, mainClockFailIrq)
        `CHK("crystal irq", 1'b0, crystalFailIrq)
        print_verdict();
    end

    // watchdog: the tests need a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        print_verdict();
    end
endmodule // test_system_reset_clock_control
